//--- inc/cdf_pkg.sv
// Constants shared by the capture data filter: register map, field positions,
// reset values, item codes and the time stamp interval.
// Assumes a 100 MHz acquisition clock.
package cdf_pkg;

	// Register byte offsets on the APB.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_PTR = 8'h0C;

	// Field positions in the filter control register.
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SEL_LSB = 1;
	localparam int CTRL_IDLE_BIT = 3;
	localparam int CTRL_TIME_BIT = 4;
	localparam int CTRL_LEAD_BIT = 5;
	localparam int CTRL_MODE_LSB = 6;
	localparam int CTRL_N_LSB = 8;

	// Field positions in the protocol and display register.
	localparam int CFG_X21_BIT = 0;
	localparam int CFG_SYNC_BIT = 1;
	localparam int CFG_DISP_LSB = 2;

	// Values after reset: filter off, both channels, every option on.
	localparam logic [31:0] CTRL_RESET = 32'h0000003C;
	localparam logic [31:0] CFG_RESET = 32'h00000008;

	// Channel selection.
	typedef enum logic [1:0] {
		CDF_SEL_TERM = 2'b00,
		CDF_SEL_LINE = 2'b01,
		CDF_SEL_BOTH = 2'b10,
		CDF_SEL_ERRS = 2'b11
	} cdf_sel_t;

	// Per-frame counting mode.
	typedef enum logic [1:0] {
		CDF_MODE_NONE = 2'b00,
		CDF_MODE_SKIP = 2'b01,
		CDF_MODE_CAPT = 2'b10,
		CDF_MODE_RSVD = 2'b11
	} cdf_mode_t;

	// Display formats.
	localparam logic [2:0] DISP_TWO = 3'h2;
	localparam logic [2:0] DISP_DSTATE = 3'h3;

	// Item kinds on the channel inputs and on the buffer write port.
	typedef enum logic [2:0] {
		CDF_K_CHAR = 3'b000,
		CDF_K_ERR = 3'b001,
		CDF_K_IDLE = 3'b010,
		CDF_K_SOF = 3'b011,
		CDF_K_EOF = 3'b100,
		CDF_K_LEAD = 3'b101,
		CDF_K_STAMP = 3'b110
	} cdf_kind_t;

	// Source codes on the buffer write port.
	localparam logic [1:0] SRC_TERM = 2'h0;
	localparam logic [1:0] SRC_LINE = 2'h1;
	localparam logic [1:0] SRC_LEAD = 2'h2;
	localparam logic [1:0] SRC_STAMP = 2'h3;

	// Time stamp interval.
	localparam int CLK_MHZ = 100;
	localparam int STAMP_PERIOD_US = 1000;
	localparam int STAMP_CYC = STAMP_PERIOD_US * CLK_MHZ;

endpackage

//--- rtl/cdf_frame_gate.sv
// Per-channel frame character counter and skip/capture decision.
// Assumes items arrive from logic on pclk and fire marks an accepted item.
`timescale 1ns/10ps
`default_nettype none
module cdf_frame_gate (
	input wire logic pclk, // Acquisition clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic fire, // Item accepted this cycle.
	input wire cdf_pkg::cdf_kind_t kind, // Kind of the offered item.
	input wire cdf_pkg::cdf_mode_t mode, // Latched counting mode.
	input wire logic [7:0] count_n, // Latched N.
	input wire logic cnt_on, // Counting in force.
	output logic keep // Item may be stored.
);

	logic [8:0] cnt_q;
	logic [8:0] cnt_d;
	wire [8:0] n_ext = {1'b0, count_n};
	wire [8:0] n_cap = (count_n == 8'h00) ? 9'h001 : n_ext;
	wire is_skip = (mode == cdf_pkg::CDF_MODE_SKIP);
	wire is_capt = (mode == cdf_pkg::CDF_MODE_CAPT);

	// The counter restarts on every opening flag and saturates so long frames never wrap back under N.
	always_comb begin
		cnt_d = cnt_q;
		if (fire && kind == cdf_pkg::CDF_K_SOF) begin
			cnt_d = 9'h000;
		end else if (fire && kind == cdf_pkg::CDF_K_CHAR && cnt_q != 9'h1FF) begin
			cnt_d = cnt_q + 9'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 9'h000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Decision per kind; errors and idles are never counted out here.
	wire char_keep = is_skip ? (cnt_q >= n_ext) : (is_capt ? (cnt_q < n_cap) : 1'b1);
	wire eof_keep = is_skip ? (cnt_q > n_ext) : 1'b1;
	wire sof_keep = !is_skip;
	assign keep = !cnt_on ||
		(kind == cdf_pkg::CDF_K_CHAR ? char_keep :
		(kind == cdf_pkg::CDF_K_EOF ? eof_keep :
		(kind == cdf_pkg::CDF_K_SOF ? sof_keep : 1'b1)));

endmodule
`default_nettype wire

//--- rtl/cdf_stamp_tick.sv
// Periodic time stamp request with a pending flag held until written.
// Assumes taken is a one-cycle pulse on pclk.
`timescale 1ns/10ps
`default_nettype none
module cdf_stamp_tick #(
	parameter int PERIOD = cdf_pkg::STAMP_CYC // Cycles between stamps.
) (
	input wire logic pclk, // Acquisition clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic enable, // Run active and stamps allowed.
	input wire logic taken, // Stamp written this cycle.
	output logic pending // A stamp waits for a buffer slot.
);

	logic [31:0] cnt_q;
	logic pend_q;
	wire wrap = (cnt_q == 32'(PERIOD - 1));

	// The interval keeps running while a stamp waits, so stamps never drift.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h00000000;
		end else if (!enable || wrap) begin
			cnt_q <= 32'h00000000;
		end else begin
			cnt_q <= cnt_q + 32'h00000001;
		end
	end

	// A new interval end wins over the write that clears the flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 1'b0;
		end else if (!enable) begin
			pend_q <= 1'b0;
		end else if (wrap) begin
			pend_q <= 1'b1;
		end else if (taken) begin
			pend_q <= 1'b0;
		end
	end

	assign pending = pend_q;

endmodule
`default_nettype wire

//--- rtl/cdf_filter_top.sv
// Capture data filter between the two serial receive channels and the capture buffer.
// Assumes channel items come from logic on pclk; lead pins arrive asynchronously.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cdf_filter_top #(
	parameter int ADDR_W = 15, // Buffer address width, 32 Kbyte.
	parameter int STAMP_PERIOD = cdf_pkg::STAMP_CYC // Cycles between stamps.
) (
	input wire logic pclk, // Acquisition clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic [7:0] paddr, // APB address.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB write.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error.
	input wire logic run_start, // Run start pulse.
	input wire logic run_stop, // Run stop pulse.
	input wire logic term_valid, // Terminal channel item valid.
	input wire cdf_pkg::cdf_kind_t term_kind, // Terminal item kind.
	input wire logic [7:0] term_data, // Terminal item data.
	output logic term_ready, // Terminal item accepted.
	input wire logic line_valid, // Line channel item valid.
	input wire cdf_pkg::cdf_kind_t line_kind, // Line item kind.
	input wire logic [7:0] line_data, // Line item data.
	output logic line_ready, // Line item accepted.
	input wire logic [4:0] lead_pins, // Interface lead levels.
	output logic buf_we, // Buffer write strobe.
	output logic [ADDR_W-1:0] buf_addr, // Buffer write address.
	output cdf_pkg::cdf_kind_t buf_kind, // Entry kind.
	output logic [1:0] buf_src, // Entry source.
	output logic [7:0] buf_data, // Entry data.
	output logic run_active, // Acquisition running.
	output logic filter_active, // Filtering in effect.
	output logic count_inactive // Counting inactive on async protocol.
);

	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] cfg_q;
	logic [31:0] cfg_d;
	logic [31:0] rd_q;
	logic [31:0] lt_ctrl_q;
	logic [1:0] lt_cfg_q;
	logic run_q;
	logic rr_q;
	logic [4:0] lead_s1_q;
	logic [4:0] lead_s2_q;
	logic [4:0] lead_last_q;
	logic [4:0] lead_val_q;
	logic lead_pend_q;
	logic we_q;
	logic [ADDR_W-1:0] addr_q;
	logic wrapped_q;
	cdf_pkg::cdf_kind_t kind_q;
	logic [1:0] src_q;
	logic [7:0] data_q;
	logic fact_q;
	logic cinact_q;
	logic [31:0] rd_mux;

	// APB decode; every access completes without wait states.
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_ctrl = (paddr == cdf_pkg::ADDR_CTRL);
	wire hit_cfg = (paddr == cdf_pkg::ADDR_CFG);
	wire hit_stat = (paddr == cdf_pkg::ADDR_STAT);
	wire hit_ptr = (paddr == cdf_pkg::ADDR_PTR);
	wire hit_any = hit_ctrl || hit_cfg || hit_stat || hit_ptr;
	wire wr_ctrl = access && pwrite && hit_ctrl;
	wire wr_cfg = access && pwrite && hit_cfg;
	assign pready = 1'b1;
	assign pslverr = access && !hit_any;

	// Register writes; display format follows lead storage being turned off.
	wire ld_off_d = !ctrl_d[cdf_pkg::CTRL_LEAD_BIT] || !ctrl_d[cdf_pkg::CTRL_TIME_BIT];
	wire [31:0] cfg_w = wr_cfg ? pwdata : cfg_q;
	wire disp_fix = ld_off_d && (cfg_w[cdf_pkg::CFG_DISP_LSB +: 3] == cdf_pkg::DISP_DSTATE);
	assign ctrl_d = wr_ctrl ? pwdata : ctrl_q;
	always_comb begin
		cfg_d = cfg_w;
		if (disp_fix) begin
			cfg_d[cdf_pkg::CFG_DISP_LSB +: 3] = cdf_pkg::DISP_TWO;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= cdf_pkg::CTRL_RESET;
			cfg_q <= cdf_pkg::CFG_RESET;
		end else begin
			ctrl_q <= ctrl_d;
			cfg_q <= cfg_d;
		end
	end

	// Read data is captured in the setup phase so it stands through the access phase.
	wire [31:0] stat_w = {28'h0000000, wrapped_q, cinact_q, fact_q, run_q};
	wire [31:0] ptr_w = 32'(addr_q);
	assign rd_mux = hit_ctrl ? ctrl_q :
		(hit_cfg ? cfg_q :
		(hit_stat ? stat_w :
		(hit_ptr ? ptr_w : 32'h00000000)));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_q <= 32'h00000000;
		end else if (setup) begin
			rd_q <= rd_mux;
		end
	end
	assign prdata = rd_q;

	// Run control; settings are copied at run start so mid-run writes wait for the next run.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
			lt_ctrl_q <= cdf_pkg::CTRL_RESET;
			lt_cfg_q <= 2'h0;
		end else if (run_start) begin
			run_q <= 1'b1;
			lt_ctrl_q <= ctrl_q;
			lt_cfg_q <= cfg_q[1:0];
		end else if (run_stop) begin
			run_q <= 1'b0;
		end
	end

	// Effective settings for the run.
	wire en = lt_ctrl_q[cdf_pkg::CTRL_EN_BIT];
	wire x21 = lt_cfg_q[cdf_pkg::CFG_X21_BIT];
	wire sync = lt_cfg_q[cdf_pkg::CFG_SYNC_BIT];
	wire [1:0] sel_raw = lt_ctrl_q[cdf_pkg::CTRL_SEL_LSB +: 2];
	wire [1:0] mode_raw = lt_ctrl_q[cdf_pkg::CTRL_MODE_LSB +: 2];
	wire [7:0] count_n = lt_ctrl_q[cdf_pkg::CTRL_N_LSB +: 8];
	wire cdf_pkg::cdf_sel_t sel = cdf_pkg::cdf_sel_t'(sel_raw);
	wire cdf_pkg::cdf_mode_t mode = cdf_pkg::cdf_mode_t'(mode_raw);
	wire mode_set = (mode == cdf_pkg::CDF_MODE_SKIP) || (mode == cdf_pkg::CDF_MODE_CAPT);
	wire time_on = !en || x21 || lt_ctrl_q[cdf_pkg::CTRL_TIME_BIT];
	wire lead_on = !en || x21 || (lt_ctrl_q[cdf_pkg::CTRL_TIME_BIT] && lt_ctrl_q[cdf_pkg::CTRL_LEAD_BIT]);
	wire idle_ok = !en || !x21 || lt_ctrl_q[cdf_pkg::CTRL_IDLE_BIT];
	wire cnt_on = en && sync && mode_set;
	wire sel_t = !en || sel == cdf_pkg::CDF_SEL_TERM || sel == cdf_pkg::CDF_SEL_BOTH;
	wire sel_l = !en || sel == cdf_pkg::CDF_SEL_LINE || sel == cdf_pkg::CDF_SEL_BOTH;

	// Per-channel pass decision; errors bypass every other filter.
	wire keep_t;
	wire keep_l;
	wire idle_t = (term_kind == cdf_pkg::CDF_K_IDLE);
	wire idle_l = (line_kind == cdf_pkg::CDF_K_IDLE);
	wire err_t = (term_kind == cdf_pkg::CDF_K_ERR);
	wire err_l = (line_kind == cdf_pkg::CDF_K_ERR);
	wire pass_t = run_q && (err_t || (sel_t && keep_t && (!idle_t || idle_ok)));
	wire pass_l = run_q && (err_l || (sel_l && keep_l && (!idle_l || idle_ok)));

	// One buffer write per cycle: the channels alternate, then leads, then stamps.
	wire stamp_pend;
	wire want_t = term_valid && pass_t;
	wire want_l = line_valid && pass_l;
	wire grant_t = want_t && (!want_l || !rr_q);
	wire grant_l = want_l && !grant_t;
	wire want_ld = lead_pend_q && lead_on && run_q;
	wire grant_ld = want_ld && !want_t && !want_l;
	wire grant_st = stamp_pend && !want_t && !want_l && !want_ld;
	wire any_grant = grant_t || grant_l || grant_ld || grant_st;
	// Filtered items are consumed at once so a dropped item never stalls its channel.
	assign term_ready = !pass_t || grant_t;
	assign line_ready = !pass_l || grant_l;
	wire fire_t = term_valid && term_ready;
	wire fire_l = line_valid && line_ready;

	cdf_frame_gate u_gate_t (
		.pclk(pclk),
		.presetn(presetn),
		.fire(fire_t),
		.kind(term_kind),
		.mode(mode),
		.count_n(count_n),
		.cnt_on(cnt_on),
		.keep(keep_t)
	);

	cdf_frame_gate u_gate_l (
		.pclk(pclk),
		.presetn(presetn),
		.fire(fire_l),
		.kind(line_kind),
		.mode(mode),
		.count_n(count_n),
		.cnt_on(cnt_on),
		.keep(keep_l)
	);

	cdf_stamp_tick #(
		.PERIOD(STAMP_PERIOD)
	) u_stamp (
		.pclk(pclk),
		.presetn(presetn),
		.enable(run_q && time_on),
		.taken(grant_st),
		.pending(stamp_pend)
	);

	// Lead pins are asynchronous, so they pass two flip-flops before change detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lead_s1_q <= 5'h00;
			lead_s2_q <= 5'h00;
			lead_last_q <= 5'h00;
		end else begin
			lead_s1_q <= lead_pins;
			lead_s2_q <= lead_s1_q;
			lead_last_q <= lead_s2_q;
		end
	end

	// A lead change waits for a slot; a newer change overwrites the waiting state and wins over the clear.
	wire lead_chg = (lead_s2_q != lead_last_q);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lead_pend_q <= 1'b0;
			lead_val_q <= 5'h00;
		end else if (!run_q || !lead_on) begin
			lead_pend_q <= 1'b0;
		end else if (lead_chg) begin
			lead_pend_q <= 1'b1;
			lead_val_q <= lead_s2_q;
		end else if (grant_ld) begin
			lead_pend_q <= 1'b0;
		end
	end

	// Round-robin pointer favours the channel that lost the last tie.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rr_q <= 1'b0;
		end else if (want_t && want_l) begin
			rr_q <= !rr_q;
		end
	end

	// Entry to be written this cycle.
	wire cdf_pkg::cdf_kind_t kind_d = grant_t ? term_kind :
		(grant_l ? line_kind :
		(grant_ld ? cdf_pkg::CDF_K_LEAD : cdf_pkg::CDF_K_STAMP));
	wire [1:0] src_d = grant_t ? cdf_pkg::SRC_TERM :
		(grant_l ? cdf_pkg::SRC_LINE :
		(grant_ld ? cdf_pkg::SRC_LEAD : cdf_pkg::SRC_STAMP));
	wire [7:0] data_d = grant_t ? term_data :
		(grant_l ? line_data :
		(grant_ld ? {3'h0, lead_val_q} : 8'h00));

	// Writes only ever go to the next address, so stored entries are never revisited except by wrap.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			we_q <= 1'b0;
			kind_q <= cdf_pkg::CDF_K_CHAR;
			src_q <= cdf_pkg::SRC_TERM;
			data_q <= 8'h00;
		end else begin
			we_q <= any_grant;
			kind_q <= kind_d;
			src_q <= src_d;
			data_q <= data_d;
		end
	end

	// Address advances after each write and wraps over the oldest entries.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q <= '0;
			wrapped_q <= 1'b0;
		end else if (we_q) begin
			addr_q <= addr_q + 1'b1;
			if (&addr_q) begin
				wrapped_q <= 1'b1;
			end
		end
	end

	// Indications for the run menu.
	wire filt_any = (sel != cdf_pkg::CDF_SEL_BOTH) || !idle_ok || !time_on || !lead_on || cnt_on;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fact_q <= 1'b0;
			cinact_q <= 1'b0;
		end else begin
			fact_q <= run_q && en && filt_any;
			cinact_q <= run_q && en && mode_set && !sync;
		end
	end

	assign buf_we = we_q;
	assign buf_addr = addr_q;
	assign buf_kind = kind_q;
	assign buf_src = src_q;
	assign buf_data = data_q;
	assign run_active = run_q;
	assign filter_active = fact_q;
	assign count_inactive = cinact_q;

endmodule
`default_nettype wire

//--- verif/cdf_chan_model.sv
// Model of one serial receive channel offering items to the filter.
// Assumes ready is combinational and sampled at the rising edge of pclk.
`timescale 1ns/10ps
`default_nettype none
module cdf_chan_model (
	input wire logic pclk, // Acquisition clock.
	input wire logic ready, // Item consumed.
	output var logic valid, // Item offered.
	output var cdf_pkg::cdf_kind_t kind, // Item kind.
	output var logic [7:0] data // Item data.
);
	// Start with nothing offered.
	initial begin
		valid = 1'b0;
		kind = cdf_pkg::CDF_K_STAMP;
		data = 8'h00;
	end
	// Offer one item and hold it until taken; the released lines show the inverse so stale reads are caught.
	task automatic put(input cdf_pkg::cdf_kind_t k, input logic [7:0] d);
		valid <= 1'b1;
		kind <= k;
		data <= d;
		@(posedge pclk);
		while (ready !== 1'b1) @(posedge pclk);
		valid <= 1'b0;
		kind <= cdf_pkg::cdf_kind_t'(~k);
		data <= ~d;
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire

//--- verif/cdf_filter_monitor.sv
// Port checker for the capture filter.
// Assumes it is bound into cdf_filter_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module cdf_filter_monitor #(
	parameter int ADDR_W = 15 // Buffer address width.
) (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Reset, active low.
	input wire logic run_start, // Run start.
	input wire logic term_valid, // Terminal valid.
	input wire cdf_pkg::cdf_kind_t term_kind, // Terminal kind.
	input wire logic term_ready, // Terminal taken.
	input wire logic line_valid, // Line valid.
	input wire logic line_ready, // Line taken.
	input wire logic buf_we, // Buffer write.
	input wire logic [ADDR_W-1:0] buf_addr, // Buffer address.
	input wire cdf_pkg::cdf_kind_t buf_kind, // Entry kind.
	input wire logic [1:0] buf_src, // Entry source.
	input wire logic run_active, // Running.
	input wire logic filter_active, // Filtering.
	input wire logic count_inactive // Counting off.
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// An item taken from one channel alone, so no arbitration delays it.
	// The filter indication is registered and lags a run start by one cycle, so that cycle is left out.
	sequence s_term;
		$past(run_active) && run_active && term_valid && term_ready && !(line_valid && line_ready);
	endsequence
	sequence s_line;
		$past(run_active) && run_active && line_valid && line_ready && !(term_valid && term_ready);
	endsequence
	// Indications lag the run flag by at most a cycle after a stop.
	AST_ADDR_STEP: assert property (buf_we |=> buf_addr == $past(buf_addr) + 1'b1)
		else $error("buffer address did not step");
	AST_ADDR_HOLD: assert property (!buf_we |=> $stable(buf_addr))
		else $error("buffer address moved without a write");
	AST_TERM_PASS: assert property (s_term ##0 !filter_active |=> buf_we && buf_src == cdf_pkg::SRC_TERM
		&& buf_kind == $past(term_kind))
		else $error("unfiltered terminal item not stored");
	AST_LINE_PASS: assert property (s_line ##0 !filter_active |=> buf_we && buf_src == cdf_pkg::SRC_LINE)
		else $error("unfiltered line item not stored");
	AST_ERR_KEPT: assert property (s_term ##0 term_kind == cdf_pkg::CDF_K_ERR |=> buf_we
		&& buf_kind == cdf_pkg::CDF_K_ERR)
		else $error("error item not stored");
	AST_RUN_START: assert property (run_start |=> run_active)
		else $error("run did not start");
	AST_CNT_OFF: assert property (count_inactive |-> run_active || $past(run_active))
		else $error("counting indication outside a run");
	AST_FLT_ON: assert property (filter_active |-> run_active || $past(run_active))
		else $error("filter indication outside a run");
endmodule
bind cdf_filter_top cdf_filter_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk, .presetn, .run_start, .term_valid,
	.term_kind, .term_ready, .line_valid, .line_ready, .buf_we, .buf_addr, .buf_kind, .buf_src, .run_active,
	.filter_active, .count_inactive);
`default_nettype wire

//--- verif/cdf_filter_top_test.sv
// Bench for the capture filter: APB register tasks, two channel models and a log of buffer writes.
// Assumes zero-wait APB and a short stamp period set here.
`timescale 1ns/10ps
`default_nettype none
module cdf_filter_top_test;
	localparam int AW = 4; // Small buffer so the wrap is exercised.
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, run_start, run_stop;
	logic term_valid, term_ready, line_valid, line_ready, buf_we, run_active, filter_active, count_inactive;
	logic [7:0] paddr, term_data, line_data, buf_data;
	logic [31:0] pwdata, prdata, rd;
	cdf_pkg::cdf_kind_t term_kind, line_kind, buf_kind;
	logic [4:0] lead_pins;
	logic [1:0] buf_src;
	logic [AW-1:0] buf_addr, exp_addr;
	string obs;
	int mismatches, n_compared, n_stamp, n_lead, cyc;
	cdf_filter_top #(.ADDR_W(AW), .STAMP_PERIOD(20)) uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .run_start, .run_stop, .term_valid, .term_kind, .term_data,
		.term_ready, .line_valid, .line_kind, .line_data, .line_ready, .lead_pins, .buf_we, .buf_addr,
		.buf_kind, .buf_src, .buf_data, .run_active, .filter_active, .count_inactive);
	cdf_chan_model u_term (.pclk, .ready(term_ready), .valid(term_valid), .kind(term_kind), .data(term_data));
	cdf_chan_model u_line (.pclk, .ready(line_ready), .valid(line_valid), .kind(line_kind), .data(line_data));
	// Free-running 100 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Entry letter: digit of the kind for terminal, a letter for line, query mark if unknown.
	function automatic byte k2c(input logic [2:0] k, input logic [1:0] s);
		if ((^{k, s}) === 1'bx) return 8'h3F;
		return (s == 2'h1 ? 8'h61 : 8'h30) + 8'(k);
	endfunction
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chks(input string g, input string e);
		n_compared++;
		if (g != e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Set up, start a run, rewrite control mid-run, feed items, toggle leads, then judge the log.
	// Items: digit = terminal kind, letter = line kind; st = {stamps, leads, filter active, counting off}.
	task automatic tc(input logic [15:0] c, input logic [4:0] g, input string it, input string ex, input logic [3:0] st);
		byte ch;
		apb(1'b1, cdf_pkg::ADDR_CTRL, {16'h0000, c});
		apb(1'b1, cdf_pkg::ADDR_CFG, {27'h0000000, g});
		run_start <= 1'b1;
		@(posedge pclk);
		run_start <= 1'b0;
		obs = "";
		n_stamp = 0;
		n_lead = 0;
		apb(1'b1, cdf_pkg::ADDR_CTRL, {16'h0000, ~c});
		for (int i = 0; i < it.len(); i++) begin
			ch = it[i];
			if (ch < 8'h61) u_term.put(cdf_pkg::cdf_kind_t'(3'(ch - 8'h30)), 8'(i));
			else u_line.put(cdf_pkg::cdf_kind_t'(3'(ch - 8'h61)), 8'(i));
		end
		lead_pins <= ~lead_pins;
		repeat (45) @(posedge pclk);
		apb(1'b0, cdf_pkg::ADDR_STAT, 32'h00000000);
		chk({29'h0, rd[2:0]}, {29'h0, st[0], st[1], 1'b1});
		chk({29'h0, run_active, count_inactive, filter_active}, {29'h0, 1'b1, st[0], st[1]});
		chk({31'h0, n_stamp > 0}, {31'h0, st[3]});
		chk({31'h0, n_lead > 0}, {31'h0, st[2]});
		chks(obs, ex);
		run_stop <= 1'b1;
		@(posedge pclk);
		run_stop <= 1'b0;
		@(posedge pclk);
	endtask
	// Log every buffer write and check that the address steps and wraps.
	always @(posedge pclk) begin
		if (buf_we === 1'b1) begin
			chk({28'h0, buf_addr}, {28'h0, exp_addr});
			exp_addr <= exp_addr + 1'b1;
			if (buf_src < 2'h2) obs = $sformatf("%s%c", obs, k2c(buf_kind, buf_src));
			else if (buf_src == 2'h2) begin
				n_lead++;
				chk({24'h0, buf_data}, {27'h0, lead_pins});
			end else begin
				n_stamp++;
				chk({24'h0, buf_data}, 32'h00000000);
			end
		end
	end
	// Cut a hang short well beyond the thousand or so cycles the run needs.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, run_start, run_stop} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		lead_pins = 5'h00;
		exp_addr = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, cdf_pkg::ADDR_CTRL, 32'h00000000);
		chk(rd, cdf_pkg::CTRL_RESET);
		apb(1'b0, cdf_pkg::ADDR_CFG, 32'h00000000);
		chk(rd, cdf_pkg::CFG_RESET);
		apb(1'b0, 8'h10, 32'h00000000);
		chk({rd[30:0], err}, 32'h00000001);
		tc(16'h0146, 5'h0B, "302a14", "302a14", 4'hC);
		tc(16'h0039, 5'h0A, "0a1b2", "01b2", 4'hE);
		tc(16'h003B, 5'h0A, "0a1b", "a1b", 4'hE);
		tc(16'h003D, 5'h0A, "0a", "0a", 4'hC);
		tc(16'h003F, 5'h0A, "0a1b2", "1b", 4'hE);
		tc(16'h0035, 5'h0B, "2c0", "0", 4'hE);
		tc(16'h000D, 5'h0B, "20", "20", 4'hC);
		tc(16'h0035, 5'h0A, "2", "2", 4'hC);
		tc(16'h002D, 5'h0A, "0", "0", 4'h2);
		tc(16'h001D, 5'h0A, "0", "0", 4'hA);
		tc(16'h027D, 5'h0A, "300043004", "04", 4'hE);
		tc(16'h007D, 5'h0A, "304", "04", 4'hE);
		tc(16'h02BD, 5'h0A, "300014", "30014", 4'hE);
		tc(16'h027D, 5'h08, "304", "304", 4'hD);
		// Timing and lead storage must be on first, or the data-and-state format is refused at once.
		apb(1'b1, cdf_pkg::ADDR_CTRL, 32'h0000003D);
		apb(1'b1, cdf_pkg::ADDR_CFG, 32'h0000000E);
		apb(1'b0, cdf_pkg::ADDR_CFG, 32'h00000000);
		chk(rd, 32'h0000000E);
		apb(1'b1, cdf_pkg::ADDR_CTRL, 32'h0000001D);
		apb(1'b0, cdf_pkg::ADDR_CFG, 32'h00000000);
		chk(rd, 32'h0000000A);
		tally_and_finish();
	end
endmodule
`default_nettype wire
